// >>> amcm_pkg.sv
// constants, register map and carrier types of the amp clock and monitor core
package amcm_pkg;

  // clock and derived cycle counts
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned CONV_TIME_NS     = 1500;
  localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned RAMP_STEP_NS     = 80;
  localparam int unsigned RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_MHZ) / 1000;
  localparam int unsigned FRAME_TIMEOUT_NS = 200000;
  localparam int unsigned FRAME_TIMEOUT_CYCLES =
    (FRAME_TIMEOUT_NS * CLK_MHZ) / 1000;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY     = 8'h08;
  localparam logic [7:0] ADDR_TEMP       = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_RATIO      = 8'h1C;

  // sample rate families
  typedef enum logic [1:0] {
    RATE_SINGLE,
    RATE_DOUBLE,
    RATE_QUAD,
    RATE_RSVD
  } amcm_rate_t;

  // control register layout, bit 0 first from the right
  typedef struct packed {
    logic [1:0] sample_rate_select;
    logic       voltage_sense_powerdown;
    logic       current_sense_powerdown;
    logic       ramp_family_441;
    logic       switch_sync_to_audio;
    logic       spread_spectrum_en;
  } amcm_ctrl_t;
  localparam int unsigned CTRL_W     = 7;
  localparam logic [6:0]  CTRL_RESET = 7'h01;

  // switching carrier controls toward the modulator
  typedef struct packed {
    logic spread_en;
    logic sync_en;
    logic ramp_441;
    logic sync_pulse;
  } amcm_carrier_t;

  // one sense sample
  localparam int unsigned SENSE_W = 16;
  typedef struct packed {
    logic               valid;
    logic [SENSE_W-1:0] data;
  } amcm_sense_t;

  // interrupt bit positions
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_CLK_FAULT = 0;
  localparam int unsigned IRQ_CLK_OK    = 1;
  localparam int unsigned IRQ_SUPPLY    = 2;
  localparam int unsigned IRQ_TEMP      = 3;

  // frame counts and gain
  localparam int unsigned CNT_W    = 10;
  localparam logic [9:0]  CNT_MAX  = 10'h3FF;
  localparam logic [9:0]  RATIO_64  = 10'h040;
  localparam logic [9:0]  RATIO_96  = 10'h060;
  localparam logic [9:0]  RATIO_128 = 10'h080;
  localparam logic [9:0]  RATIO_192 = 10'h0C0;
  localparam logic [9:0]  RATIO_256 = 10'h100;
  localparam logic [9:0]  RATIO_384 = 10'h180;
  localparam logic [9:0]  RATIO_512 = 10'h200;
  localparam logic [7:0]  GAIN_FULL = 8'hFF;
  localparam logic [7:0]  GAIN_ZERO = 8'h00;

endpackage : amcm_pkg

// >>> amcm_sar_seq.sv
// interleaved supply and die temperature converter sequencer
`timescale 1ns/100ps
module amcm_sar_seq #(
  parameter int unsigned CONV_CYCLES = amcm_pkg::CONV_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] sar_code,
  output logic             sar_start,
  output logic             sar_channel,
  output logic [11:0]      supply_result,
  output logic [11:0]      temp_result,
  output logic             supply_valid,
  output logic             temp_valid
);
  localparam int unsigned CW = $clog2(CONV_CYCLES);

  logic [CW-1:0] cnt_reg, cnt_next;
  logic          chan_reg, chan_next;
  logic          start_reg, start_next;
  logic          primed_reg, primed_next;
  logic [11:0]   supply_reg, supply_next;
  logic [11:0]   temp_reg, temp_next;
  logic          sval_reg, sval_next;
  logic          tval_reg, tval_next;
  logic          last;

  // the schedule checks below share this clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // conversion timer, channel toggle and whole-word result capture
  always_comb begin
    last        = (cnt_reg == CW'(CONV_CYCLES - 1));
    cnt_next    = last ? '0 : cnt_reg + CW'(1);
    chan_next   = last ? ~chan_reg : chan_reg;
    start_next  = last;
    primed_next = primed_reg | last;
    supply_next = supply_reg;
    temp_next   = temp_reg;
    sval_next   = 1'b0;
    tval_next   = 1'b0;
    if (last && primed_reg && !chan_reg) begin
      supply_next = sar_code;
      sval_next   = 1'b1;
    end
    if (last && primed_reg && chan_reg) begin
      temp_next = sar_code;
      tval_next = 1'b1;
    end
  end

  // sequencer state; counter starts at its end so conversion 0 begins at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg    <= CW'(CONV_CYCLES - 1);
      chan_reg   <= 1'b1;
      start_reg  <= 1'b0;
      primed_reg <= 1'b0;
      supply_reg <= 12'h000;
      temp_reg   <= 12'h000;
      sval_reg   <= 1'b0;
      tval_reg   <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      chan_reg   <= chan_next;
      start_reg  <= start_next;
      primed_reg <= primed_next;
      supply_reg <= supply_next;
      temp_reg   <= temp_next;
      sval_reg   <= sval_next;
      tval_reg   <= tval_next;
    end
  end

  assign sar_start     = start_reg;
  assign sar_channel   = chan_reg;
  assign supply_result = supply_reg;
  assign temp_result   = temp_reg;
  assign supply_valid  = sval_reg;
  assign temp_valid    = tval_reg;

  // checks on the conversion schedule
  interleave_a: assert property (
    sval_reg |-> ##300 tval_reg)
    else $error("temp result did not follow supply result by one slot");
  refresh_a: assert property (
    tval_reg |-> ##300 sval_reg)
    else $error("supply result not refreshed within two slots");
  result_atomic_a: assert property (
    !sval_next |=> $stable(supply_reg))
    else $error("supply result changed without a completed conversion");
  result_code_a: assert property (
    sval_reg |-> supply_reg == $past(sar_code) && !$past(chan_reg))
    else $error("supply result not taken from the supply conversion");

endmodule : amcm_sar_seq

// >>> amcm_core.sv
// amp clock and monitor core: apb registers, clock check, ramp and monitors
`timescale 1ns/100ps
module amcm_core #(
  parameter int unsigned FRAME_TIMEOUT = amcm_pkg::FRAME_TIMEOUT_CYCLES,
  parameter int unsigned CONV_CYCLES   = amcm_pkg::CONV_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic                  serial_bit_clock,
  input  wire logic                  frame_sync_in,
  input  wire logic [11:0]           sar_code,
  output logic                       sar_start,
  output logic                       sar_channel,
  output logic [11:0]                supply_to_limiter,
  output logic                       supply_to_limiter_valid,
  input  wire amcm_pkg::amcm_sense_t isense_in,
  input  wire amcm_pkg::amcm_sense_t vsense_in,
  output amcm_pkg::amcm_sense_t      isense_out,
  output amcm_pkg::amcm_sense_t      vsense_out,
  output logic                       current_sense_powerdown,
  output logic                       voltage_sense_powerdown,
  output amcm_pkg::amcm_carrier_t    carrier,
  output logic [7:0]                 playback_gain
);
  localparam int unsigned TO_W = $clog2(FRAME_TIMEOUT + 1);
  localparam int unsigned RW   = $clog2(amcm_pkg::RAMP_STEP_CYCLES);
  localparam int unsigned IW   = amcm_pkg::IRQ_W;

  amcm_pkg::amcm_ctrl_t    ctrl_reg, ctrl_next;
  amcm_pkg::amcm_carrier_t car_reg, car_next;
  amcm_pkg::amcm_sense_t   isns_reg, isns_next;
  amcm_pkg::amcm_sense_t   vsns_reg, vsns_next;
  logic [IW-1:0]           ist_reg, ist_next;
  logic [IW-1:0]           ien_reg, ien_next;
  logic [IW-1:0]           ev;
  logic [31:0]             rd_reg, rd_next;
  logic [31:0]             rmux;
  logic                    mapped, apb_wr, wr0;
  logic                    bclk_meta_reg, bclk_sync_reg, bclk_prev_reg;
  logic                    fs_meta_reg, fs_sync_reg, fs_prev_reg;
  logic                    bclk_edge, fs_edge;
  logic [9:0]              edge_cnt_reg, edge_cnt_next;
  logic [9:0]              ratio_reg, ratio_next;
  logic                    clk_ok_reg, clk_ok_next;
  logic                    seen_reg, seen_next;
  logic [TO_W-1:0]         to_cnt_reg, to_cnt_next;
  logic                    timeout;
  logic [RW-1:0]           step_reg, step_next;
  logic                    step_tick;
  logic [7:0]              gain_reg, gain_next;
  logic [11:0]             supply_res, temp_res;
  logic                    supply_vld, temp_vld;
  // assertions below share this clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // allowed frame lengths per sample rate family
  function automatic logic ratio_ok(input logic [9:0] n,
                                    input logic [1:0] rate);
    logic q;
    logic d;
    logic s;
    q = (n == amcm_pkg::RATIO_64) || (n == amcm_pkg::RATIO_96) ||
        (n == amcm_pkg::RATIO_128);
    d = q || (n == amcm_pkg::RATIO_192) || (n == amcm_pkg::RATIO_256);
    s = d || (n == amcm_pkg::RATIO_384) || (n == amcm_pkg::RATIO_512);
    case (rate)
      amcm_pkg::RATE_SINGLE: ratio_ok = s;
      amcm_pkg::RATE_DOUBLE: ratio_ok = d;
      amcm_pkg::RATE_QUAD:   ratio_ok = q;
      default:               ratio_ok = 1'b0;
    endcase
  endfunction : ratio_ok

  // converter sequencing and result capture
  amcm_sar_seq #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_sar (
    .pclk          (pclk),
    .presetn       (presetn),
    .sar_code      (sar_code),
    .sar_start     (sar_start),
    .sar_channel   (sar_channel),
    .supply_result (supply_res),
    .temp_result   (temp_res),
    .supply_valid  (supply_vld),
    .temp_valid    (temp_vld)
  );
  assign supply_to_limiter       = supply_res;
  assign supply_to_limiter_valid = supply_vld;

  // apb decode; zero wait states, error on unmapped offsets
  always_comb begin
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    case (paddr)
      amcm_pkg::ADDR_CTRL:       rmux[6:0]   = ctrl_reg;
      amcm_pkg::ADDR_STATUS:     rmux[15:0]  = {gain_reg, 6'h00,
                                   gain_reg == amcm_pkg::GAIN_ZERO,
                                   clk_ok_reg};
      amcm_pkg::ADDR_SUPPLY:     rmux[11:0]  = supply_res;
      amcm_pkg::ADDR_TEMP:       rmux[11:0]  = temp_res;
      amcm_pkg::ADDR_IRQ_STATUS: rmux[IW-1:0] = ist_reg;
      amcm_pkg::ADDR_IRQ_CLEAR:  rmux        = 32'h0000_0000;
      amcm_pkg::ADDR_IRQ_ENABLE: rmux[IW-1:0] = ien_reg;
      amcm_pkg::ADDR_RATIO:      rmux[9:0]   = ratio_reg;
      default:                   mapped      = 1'b0;
    endcase
    apb_wr  = psel && penable && pwrite;
    wr0     = apb_wr && pstrb[0];
    rd_next = (psel && !penable && !pwrite) ? rmux : rd_reg;
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rd_reg;

  // software writable registers and sticky interrupt status
  always_comb begin
    ctrl_next = ctrl_reg;
    ien_next  = ien_reg;
    if (wr0 && paddr == amcm_pkg::ADDR_CTRL)
      ctrl_next = amcm_pkg::amcm_ctrl_t'(pwdata[amcm_pkg::CTRL_W-1:0]);
    if (wr0 && paddr == amcm_pkg::ADDR_IRQ_ENABLE)
      ien_next = pwdata[IW-1:0];
    ev = '0;
    ev[amcm_pkg::IRQ_CLK_FAULT] = clk_ok_reg && !clk_ok_next;
    ev[amcm_pkg::IRQ_CLK_OK]    = !clk_ok_reg && clk_ok_next;
    ev[amcm_pkg::IRQ_SUPPLY]    = supply_vld;
    ev[amcm_pkg::IRQ_TEMP]      = temp_vld;
    ist_next = ist_reg;
    if (wr0 && paddr == amcm_pkg::ADDR_IRQ_CLEAR)
      ist_next = ist_reg & ~pwdata[IW-1:0];
    ist_next = ist_next | ev;                                 // set wins
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= amcm_pkg::amcm_ctrl_t'(amcm_pkg::CTRL_RESET);
      ien_reg  <= '0;
      ist_reg  <= '0;
      rd_reg   <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ien_reg  <= ien_next;
      ist_reg  <= ist_next;
      rd_reg   <= rd_next;
    end
  end
  assign irq = |(ist_reg & ien_reg);

  // two-stage synchronisers and edge finders for the audio clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_meta_reg <= 1'b0;
      bclk_sync_reg <= 1'b0;
      bclk_prev_reg <= 1'b0;
      fs_meta_reg   <= 1'b0;
      fs_sync_reg   <= 1'b0;
      fs_prev_reg   <= 1'b0;
    end else begin
      bclk_meta_reg <= serial_bit_clock;
      bclk_sync_reg <= bclk_meta_reg;
      bclk_prev_reg <= bclk_sync_reg;
      fs_meta_reg   <= frame_sync_in;
      fs_sync_reg   <= fs_meta_reg;
      fs_prev_reg   <= fs_sync_reg;
    end
  end
  assign bclk_edge = bclk_sync_reg && !bclk_prev_reg;
  assign fs_edge   = fs_sync_reg && !fs_prev_reg;

  // frame length measurement, validity and lost-frame timeout
  always_comb begin
    timeout       = (to_cnt_reg == TO_W'(FRAME_TIMEOUT));
    edge_cnt_next = edge_cnt_reg;
    ratio_next    = ratio_reg;
    clk_ok_next   = clk_ok_reg;
    seen_next     = seen_reg;
    to_cnt_next   = timeout ? to_cnt_reg : to_cnt_reg + TO_W'(1);
    if (fs_edge) begin
      ratio_next    = edge_cnt_reg;
      clk_ok_next   = seen_reg &&
                      ratio_ok(edge_cnt_reg, ctrl_reg.sample_rate_select);
      seen_next     = 1'b1;
      edge_cnt_next = bclk_edge ? 10'h001 : 10'h000;
      to_cnt_next   = '0;
    end else begin
      if (bclk_edge && edge_cnt_reg != amcm_pkg::CNT_MAX)
        edge_cnt_next = edge_cnt_reg + 10'h001;
      if (timeout) begin
        clk_ok_next = 1'b0;
        seen_next   = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_reg <= 10'h000;
      ratio_reg    <= 10'h000;
      clk_ok_reg   <= 1'b0;
      seen_reg     <= 1'b0;
      to_cnt_reg   <= '0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
      ratio_reg    <= ratio_next;
      clk_ok_reg   <= clk_ok_next;
      seen_reg     <= seen_next;
      to_cnt_reg   <= to_cnt_next;
    end
  end

  // playback gain ramp: down on a bad clock, back up once it is good
  always_comb begin
    step_tick = (step_reg == RW'(amcm_pkg::RAMP_STEP_CYCLES - 1));
    step_next = step_reg + RW'(1);
    gain_next = gain_reg;
    if (step_tick && !clk_ok_reg && gain_reg != amcm_pkg::GAIN_ZERO)
      gain_next = gain_reg - 8'h01;
    if (step_tick && clk_ok_reg && gain_reg != amcm_pkg::GAIN_FULL)
      gain_next = gain_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= '0;
      gain_reg <= amcm_pkg::GAIN_ZERO;
    end else begin
      step_reg <= step_next;
      gain_reg <= gain_next;
    end
  end
  assign playback_gain = gain_reg;

  // carrier controls and sense sample gating
  always_comb begin
    car_next.spread_en  = ctrl_reg.spread_spectrum_en;
    car_next.sync_en    = ctrl_reg.switch_sync_to_audio;
    car_next.ramp_441   = ctrl_reg.ramp_family_441;
    car_next.sync_pulse = ctrl_reg.switch_sync_to_audio && fs_edge;
    isns_next.valid = isense_in.valid;
    isns_next.data  = ctrl_reg.current_sense_powerdown ?
                      '0 : isense_in.data;
    vsns_next.valid = vsense_in.valid;
    vsns_next.data  = ctrl_reg.voltage_sense_powerdown ?
                      '0 : vsense_in.data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_reg  <= '0;
      isns_reg <= '0;
      vsns_reg <= '0;
    end else begin
      car_reg  <= car_next;
      isns_reg <= isns_next;
      vsns_reg <= vsns_next;
    end
  end
  assign carrier                 = car_reg;
  assign isense_out              = isns_reg;
  assign vsense_out              = vsns_reg;
  assign current_sense_powerdown = ctrl_reg.current_sense_powerdown;
  assign voltage_sense_powerdown = ctrl_reg.voltage_sense_powerdown;

  // checks on control, clock check, ramp and interrupts
  spread_write_a: assert property (
    wr0 && paddr == amcm_pkg::ADDR_CTRL |-> ##2
    carrier.spread_en == $past(pwdata[0], 2))
    else $error("spread enable did not follow the control write");
  sync_pulse_a: assert property (
    carrier.sync_pulse |-> $past(ctrl_reg.switch_sync_to_audio))
    else $error("sync pulse while carrier runs from oscillator");
  bad_ratio_a: assert property (
    fs_edge && !ratio_ok(edge_cnt_reg, ctrl_reg.sample_rate_select)
    |=> !clk_ok_reg)
    else $error("unsupported frame length accepted");
  good_ratio_a: assert property (
    fs_edge && seen_reg &&
    ratio_ok(edge_cnt_reg, ctrl_reg.sample_rate_select) |=> clk_ok_reg)
    else $error("supported frame length rejected");
  frame_count_a: assert property (
    fs_edge |=> ratio_reg == $past(edge_cnt_reg))
    else $error("frame length not captured at frame start");
  ramp_down_a: assert property (
    !clk_ok_reg && gain_reg != amcm_pkg::GAIN_ZERO |->
    ##[1:16] gain_reg != $past(gain_reg) || clk_ok_reg)
    else $error("gain did not step down on a bad clock");
  ramp_up_a: assert property (
    clk_ok_reg && step_tick && gain_reg != amcm_pkg::GAIN_FULL
    |=> gain_reg == $past(gain_reg) + 8'h01)
    else $error("gain did not step up after clock recovery");
  sense_null_a: assert property (
    $past(ctrl_reg.current_sense_powerdown) |-> isense_out.data == '0)
    else $error("powered down current sense passed data");
  irq_sticky_a: assert property (
    ev[amcm_pkg::IRQ_CLK_FAULT] |=> ist_reg[amcm_pkg::IRQ_CLK_FAULT])
    else $error("clock fault event lost");

  fault_recover_c: cover property (@(posedge pclk) disable iff (!presetn)
    ev[amcm_pkg::IRQ_CLK_FAULT] ##[1:1000] ev[amcm_pkg::IRQ_CLK_OK]);
  gain_zero_c: cover property (@(posedge pclk) disable iff (!presetn)
    !clk_ok_reg && gain_reg == amcm_pkg::GAIN_ZERO);
  temp_update_c: cover property (@(posedge pclk) disable iff (!presetn)
    temp_vld);
  irq_raise_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));

endmodule : amcm_core

// >>> amcm_host_model.sv
// audio host model: serial bit clock and frame sync at a set ratio
`timescale 1ns/100ps
module amcm_host_model (
  input  wire logic       run,
  input  wire logic [9:0] ratio,
  output logic            serial_bit_clock,
  output logic            frame_sync_in
);
  int i;
  // one frame sync bit per frame; the bit clock idles low when stopped
  initial begin
    serial_bit_clock = 1'h0;
    frame_sync_in = 1'h0;
    forever begin
      wait (run);
      for (i = 0; i < ratio; i++) begin
        frame_sync_in = (i == 0);
        #80 serial_bit_clock = 1'h1;
        #80 serial_bit_clock = 1'h0;
      end
    end
  end
endmodule : amcm_host_model

// >>> tb.sv
// testbench of the amp clock and monitor core
`timescale 1ns/100ps
module tb;
  logic                    pclk, presetn, psel, penable, pwrite, run;
  logic                    pready, pslverr, perr, irq, sv_valid, bclk, fs;
  logic                    ipd, vpd, ss, sc;
  logic [7:0]              paddr, gain;
  logic [31:0]             pwdata, prdata, rd;
  logic [3:0]              pstrb;
  logic [11:0]             sar_code, sv, tv;
  logic [9:0]              ratio;
  amcm_pkg::amcm_sense_t   isense_in, vsense_in, isense_out, vsense_out;
  amcm_pkg::amcm_carrier_t carrier;
  int                      mismatches, check_count, seed, n;

  amcm_core #(.FRAME_TIMEOUT(20000)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .serial_bit_clock(bclk),
    .frame_sync_in(fs), .sar_code(sar_code), .sar_start(ss), .sar_channel(sc),
    .supply_to_limiter(sv), .supply_to_limiter_valid(sv_valid),
    .isense_in(isense_in), .vsense_in(vsense_in), .isense_out(isense_out),
    .vsense_out(vsense_out), .current_sense_powerdown(ipd),
    .voltage_sense_powerdown(vpd), .carrier(carrier), .playback_gain(gain));
  amcm_host_model u_host (.run(run), .ratio(ratio),
    .serial_bit_clock(bclk), .frame_sync_in(fs));

  // 200 MHz clock
  initial pclk = 1'h0;
  always #2.5 pclk = ~pclk;

  task report_and_stop;
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task hang;
    mismatches++;
    report_and_stop;
  endtask : hang

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 50) hang;
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task poll(input logic [7:0] a, input logic [31:0] m, e, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      apb(1'h0, a, 32'h0);
      if ((rd & m) === e) break;
    end
    if (k == lim) hang;
  endtask : poll

  function automatic logic [31:0] ctrl_val(input logic [1:0] rate,
    input logic pd, input logic sync, input logic ss);
    return {25'h0, rate, pd, pd, sync, sync, ss};
  endfunction : ctrl_val

  initial begin
    seed = 5358;
    {presetn, psel, penable, pwrite, run, paddr, pwdata} = '0;
    {mismatches, check_count} = '0;
    pstrb = 4'hF;
    ratio = amcm_pkg::RATIO_64;
    sar_code = 12'($random(seed));
    isense_in = {1'h1, 16'($random(seed))};
    vsense_in = {1'h1, 16'($random(seed))};
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, amcm_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(carrier.spread_en, 1'h1);
    chk(isense_out, isense_in);
    chk(vsense_out, vsense_in);
    apb(1'h1, amcm_pkg::ADDR_CTRL, ctrl_val(2'h0, 1'h1, 1'h1, 1'h0));
    repeat (3) @(posedge pclk);
    chk(carrier[3:1], 3'h3);
    chk({ipd, vpd, isense_out.data}, 18'h30000);
    chk(vsense_out.data, 16'h0);
    // supply result on the limiter path and in its register
    for (n = 0; n < 700; n++) begin
      @(negedge pclk);
      if (sv_valid === 1'h1) break;
    end
    if (n == 700) hang;
    chk(sv, sar_code);
    chk({ss, sc}, 2'h3);
    apb(1'h0, amcm_pkg::ADDR_SUPPLY, 32'h0);
    chk(rd, sar_code);
    tv = 12'($random(seed));
    sar_code <= tv;
    poll(amcm_pkg::ADDR_TEMP, 32'hFFF, tv, 300);
    // clock check: good single-speed ratio, then bad and good quad ratios
    apb(1'h1, amcm_pkg::ADDR_CTRL, ctrl_val(2'h0, 1'h0, 1'h0, 1'h1));
    run <= 1'h1;
    poll(amcm_pkg::ADDR_STATUS, 32'h1, 32'h1, 9000);
    apb(1'h0, amcm_pkg::ADDR_RATIO, 32'h0);
    chk(rd, amcm_pkg::RATIO_64);
    poll(amcm_pkg::ADDR_STATUS, 32'hFF00, 32'hFF00, 9000);
    chk(gain, 8'hFF);
    apb(1'h1, amcm_pkg::ADDR_IRQ_ENABLE, 32'h1);
    apb(1'h1, amcm_pkg::ADDR_CTRL, ctrl_val(2'h2, 1'h0, 1'h0, 1'h1));
    ratio <= amcm_pkg::RATIO_192;
    poll(amcm_pkg::ADDR_STATUS, 32'h3, 32'h2, 9000);
    chk(irq, 1'h1);
    chk(gain, 8'h00);
    apb(1'h1, amcm_pkg::ADDR_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'h0);
    // drop the recovered flag of the first lock so the next one is seen
    apb(1'h1, amcm_pkg::ADDR_IRQ_CLEAR, 32'h2);
    ratio <= amcm_pkg::RATIO_128;
    poll(amcm_pkg::ADDR_STATUS, 32'hFF01, 32'hFF01, 9000);
    apb(1'h0, amcm_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'h1, amcm_pkg::ADDR_IRQ_CLEAR, 32'h2);
    apb(1'h0, amcm_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    // reserved rate rejects every frame; double speed takes 256
    apb(1'h1, amcm_pkg::ADDR_CTRL, ctrl_val(2'h3, 1'h0, 1'h0, 1'h1));
    poll(amcm_pkg::ADDR_STATUS, 32'h1, 32'h0, 9000);
    apb(1'h1, amcm_pkg::ADDR_CTRL, ctrl_val(2'h1, 1'h0, 1'h0, 1'h1));
    ratio <= amcm_pkg::RATIO_256;
    poll(amcm_pkg::ADDR_STATUS, 32'h1, 32'h1, 9000);
    apb(1'h0, amcm_pkg::ADDR_RATIO, 32'h0);
    chk(rd, amcm_pkg::RATIO_256);
    apb(1'h0, 8'h20, 32'h0);
    chk(perr, 1'h1);
    chk(rd, 32'h0);
    report_and_stop;
  end
endmodule : tb
